// file: drive_status_checker_properties.sv
// checker for the status word and the object port of the velocity block
// assumes a bind onto the block top, one clock, reset active high
`timescale 1ns/1ps
`default_nettype none
module drive_status_checker #(
    parameter RAMP_TICK_CYCLES = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] power_state,
    input wire logic voltage_present_flag,
    input wire logic fault_active,
    input wire logic warning_active,
    input wire logic fieldbus_in_sync,
    input wire logic goal_reached_flag,
    input wire logic feedback_loop_on,
    input wire logic [1:0] mode_specific_bits,
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic od_ack,
    input wire logic od_err,
    input wire logic [15:0] status_word
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // inhibited bit and low nibble per power state
    localparam logic [4:0] CODE [0:7] = '{5'h00, 5'h10, 5'h01, 5'h03, 5'h07, 5'h07, 5'h0f, 5'h08};
    // ----------------------------------------
    // sequences
    // ----------------------------------------
    sequence s_live;
        !rst ##1 1'b1;
    endsequence
    sequence s_ro_write;
        od_req && od_write && (od_index == 16'h6041 || od_index == 16'h6043 || od_index == 16'h6044);
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_remote;
        s_live |-> status_word[9];
    endproperty
    a_remote: assert property (p_remote) else $error("remote bit not one");
    property p_sync;
        s_live |-> status_word[8] == $past(fieldbus_in_sync);
    endproperty
    a_sync: assert property (p_sync) else $error("sync bit wrong");
    property p_loop;
        s_live |-> status_word[15] == ($past(feedback_loop_on) && $past(power_state) == 3'h4);
    endproperty
    a_loop: assert property (p_loop) else $error("loop bit wrong");
    property p_fast_halt;
        s_live |-> status_word[5] == ($past(power_state) != 3'h5 && $past(power_state) != 3'h0);
    endproperty
    a_fast_halt: assert property (p_fast_halt) else $error("fast halt bit wrong");
    property p_state_code;
        s_live ##0 !$past(fault_active) |-> {status_word[6], status_word[3:0]} == CODE[$past(power_state)];
    endproperty
    a_state_code: assert property (p_state_code) else $error("state code wrong");
    property p_flags;
        s_live |-> status_word[4] == $past(voltage_present_flag) && status_word[7] == $past(warning_active)
            && status_word[10] == $past(goal_reached_flag) && status_word[13:12] == $past(mode_specific_bits)
            && (status_word[3] || !$past(fault_active));
    endproperty
    a_flags: assert property (p_flags) else $error("status flag wrong");
    property p_ack;
        s_live |-> od_ack == $past(od_req) && (od_ack || !od_err);
    endproperty
    a_ack: assert property (p_ack) else $error("answer pulse wrong");
    property p_ro;
        s_ro_write |=> od_ack && od_err;
    endproperty
    a_ro: assert property (p_ro) else $error("read only write accepted");
endmodule // drive_status_checker

bind drive_status_velocity_mode drive_status_checker #(.RAMP_TICK_CYCLES(RAMP_TICK_CYCLES)) chk_inst (
    .clock(clock), .rst(rst), .power_state(power_state), .voltage_present_flag(voltage_present_flag),
    .fault_active(fault_active), .warning_active(warning_active), .fieldbus_in_sync(fieldbus_in_sync),
    .goal_reached_flag(goal_reached_flag), .feedback_loop_on(feedback_loop_on),
    .mode_specific_bits(mode_specific_bits), .od_req(od_req), .od_write(od_write), .od_index(od_index),
    .od_ack(od_ack), .od_err(od_err), .status_word(status_word));
`default_nettype wire

// file: drive_status_regs.vh
// object indices, subindices, reset values and status bit positions
// assumes inclusion by a single design file under one clock
`ifndef DRIVE_STATUS_REGS_VH
`define DRIVE_STATUS_REGS_VH

// ----------------------------------------
// object indices and subindices
// ----------------------------------------
`define IDX_STATE_REPORT 16'h6041
`define IDX_VEL_TARGET 16'h6042
`define IDX_VEL_DEMAND 16'h6043
`define IDX_VEL_ACTUAL 16'h6044
`define IDX_VEL_LIMITS 16'h6046
`define IDX_ACCEL_RAMP 16'h6048
`define IDX_DECEL_RAMP 16'h6049
`define IDX_FAST_STOP_RAMP 16'h604a
`define IDX_UNIT_FACTOR 16'h604c
`define SUB_VALUE 8'h00
`define SUB_FIRST 8'h01
`define SUB_SECOND 8'h02
`define SUB_COUNT_PAIR 32'h00000002

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_STATE_REPORT 16'h0000
`define RST_VEL_TARGET 16'h00c8
`define RST_VEL_VALUE 16'h0000
`define RST_LOWER_LIMIT 32'h00000000
`define RST_UPPER_LIMIT 32'h00007530
`define RST_RAMP_SPEED 32'h000001f4
`define RST_FAST_SPEED 32'h00001388
`define RST_RAMP_TIME 16'h0001
`define RST_UNIT_FACTOR 32'h00000001

// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define BIT_READY 0
`define BIT_SWITCHED_ON 1
`define BIT_OP_ENABLED 2
`define BIT_FAULT 3
`define BIT_VOLTAGE 4
`define BIT_FAST_HALT 5
`define BIT_INHIBITED 6
`define BIT_WARNING 7
`define BIT_SYNC 8
`define BIT_REMOTE 9
`define BIT_GOAL 10
`define BIT_LIMIT 11
`define BIT_MODE_LO 12
`define BIT_MODE_HI 13
`define BIT_SPARE 14
`define BIT_LOOP 15

// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_MHZ 100
`define RAMP_UNIT_US 1000

`endif

// file: drive_status_velocity_mode.v
// status word encoding and velocity mode setpoint path of a drive
// assumes one 100 MHz clock; all inputs come from logic on that clock
`timescale 1ns/1ps
`default_nettype none
`include "drive_status_regs.vh"

// Contract
// R1 - sixteen bit status word with fixed flag layout
// R2 - fast halt bit low during quick stop
// R3 - sync bit follows fieldbus synchronisation
// R4 - remote bit always reads one
// R5 - loop bit only when enabled and looping
// R6 - fault, voltage, warning, goal, limit flags
// R7 - bits twelve, thirteen belong to mode
// R8 - power state low codes per table
// R9 - quick stop, fault codes per table
// R10 - signed target speed, writable, reset 00c8
// R11 - demand and actual read only, zero
// R12 - below minimum: use minimum, set limit
// R13 - above maximum: use maximum, set limit
// R14 - min and max limits, given resets
// R15 - acceleration ramp speed and time steps
// R16 - deceleration ramp speed and time steps
// R17 - quick stop uses its own ramp
// R18 - ramp equals speed step per time
// R19 - rpm equals speed times num over den
// R20 - status word read only, reset zero
// R21 - demand steps toward clamped target
// R22 - limit flag clears once target in range
module drive_status_velocity_mode #(
    parameter RAMP_TICK_CYCLES = `RAMP_UNIT_US * `CLOCK_MHZ
) (
    input wire clock,
    input wire rst,
    input wire [2:0] power_state,
    input wire voltage_present_flag,
    input wire fault_active,
    input wire warning_active,
    input wire fieldbus_in_sync,
    input wire goal_reached_flag,
    input wire feedback_loop_on,
    input wire [1:0] mode_specific_bits,
    input wire [15:0] velocity_measured,
    input wire od_req,
    input wire od_write,
    input wire [15:0] od_index,
    input wire [7:0] od_sub,
    input wire [31:0] od_wdata,
    output reg [31:0] od_rdata,
    output reg od_ack,
    output reg od_err,
    output reg [15:0] status_word,
    output reg [15:0] velocity_demand,
    output reg [31:0] speed_rpm
);

// ----------------------------------------
// power states
// ----------------------------------------
localparam [2:0] ST_NOT_READY = 3'h0;
localparam [2:0] ST_INHIBITED = 3'h1;
localparam [2:0] ST_READY = 3'h2;
localparam [2:0] ST_SWITCHED_ON = 3'h3;
localparam [2:0] ST_OP_ENABLED = 3'h4;
localparam [2:0] ST_FAST_HALT = 3'h5;
localparam [2:0] ST_FAULT_REACT = 3'h6;
localparam [2:0] ST_FAULT = 3'h7;
localparam [15:0] SPEED_MAX = 16'h7fff;
localparam [31:0] TICK_LAST = RAMP_TICK_CYCLES - 1;

// ----------------------------------------
// functions
// ----------------------------------------
// magnitude of a signed speed
function [15:0] mag16;
    input [15:0] v;
    begin
        mag16 = v[15] ? (16'h0000 - v) : v;
    end
endfunction

// saturate a 32-bit amount to the speed range
function [15:0] sat16;
    input [31:0] v;
    begin
        sat16 = (v > {16'h0000, SPEED_MAX}) ? SPEED_MAX : v[15:0];
    end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg [15:0] velocity_target_reg;
reg [15:0] velocity_actual_reg;
reg [31:0] velocity_lower_limit_reg;
reg [31:0] velocity_upper_limit_reg;
reg [31:0] accel_speed_step_reg;
reg [15:0] accel_time_step_reg;
reg [31:0] decel_speed_step_reg;
reg [15:0] decel_time_step_reg;
reg [31:0] fast_stop_speed_step_reg;
reg [15:0] fast_stop_time_step_reg;
reg [31:0] speed_unit_numerator_reg;
reg [31:0] speed_unit_denominator_reg;
reg internal_limit_flag_reg;
reg [31:0] tick_count_reg;
reg tick_reg;
reg [15:0] time_count_reg;
reg [63:0] rpm_product;
reg [63:0] rpm_quotient;
reg [31:0] rpm_value;

// ----------------------------------------
// target clamping
// ----------------------------------------
reg [15:0] target_mag;
reg [15:0] lower_mag;
reg [15:0] upper_mag;
reg [15:0] clamp_mag;
reg clamp_hit;
reg [15:0] clamped_target;

// clamp target magnitude into the limits
always @* begin
    target_mag = mag16(velocity_target_reg);
    lower_mag = sat16(velocity_lower_limit_reg); // R14
    upper_mag = sat16(velocity_upper_limit_reg); // R14
    clamp_mag = target_mag;
    clamp_hit = 1'b0;
    if ({16'h0000, target_mag} < velocity_lower_limit_reg) begin
        clamp_mag = lower_mag; // R12
        clamp_hit = 1'b1; // R12
    end else if ({16'h0000, target_mag} > velocity_upper_limit_reg) begin
        clamp_mag = upper_mag; // R13
        clamp_hit = 1'b1; // R13
    end
    clamped_target = velocity_target_reg[15] ? (16'h0000 - clamp_mag) : clamp_mag;
end

// ----------------------------------------
// ramp selection
// ----------------------------------------
reg [15:0] goal;
reg rising;
reg [15:0] step;
reg [15:0] period;
reg [16:0] diff;
reg [16:0] diff_mag;
reg [15:0] demand_next;

// choose goal and ramp, then one step toward the goal
always @* begin
    goal = 16'h0000;
    if (power_state == ST_OP_ENABLED) begin
        goal = clamped_target; // R21
    end
    rising = (velocity_demand == 16'h0000) ||
        ((goal[15] == velocity_demand[15]) && (mag16(goal) > mag16(velocity_demand)));
    if (power_state == ST_FAST_HALT) begin
        step = sat16(fast_stop_speed_step_reg); // R17
        period = fast_stop_time_step_reg; // R17
    end else if (rising) begin
        step = sat16(accel_speed_step_reg); // R15
        period = accel_time_step_reg; // R15
    end else begin
        step = sat16(decel_speed_step_reg); // R16
        period = decel_time_step_reg; // R16
    end
    diff = {goal[15], goal} - {velocity_demand[15], velocity_demand};
    diff_mag = diff[16] ? (17'h00000 - diff) : diff;
    if (diff_mag <= {1'b0, step}) begin
        demand_next = goal; // R21
    end else if (diff[16]) begin
        demand_next = velocity_demand - step; // R21
    end else begin
        demand_next = velocity_demand + step; // R21
    end
end

// ----------------------------------------
// ramp timing
// ----------------------------------------
// base tick, one per ramp time unit
always @(posedge clock or posedge rst) begin
    if (rst) begin
        tick_count_reg <= 32'h00000000;
        tick_reg <= 1'b0;
    end else if (tick_count_reg >= TICK_LAST) begin
        tick_count_reg <= 32'h00000000;
        tick_reg <= 1'b1;
    end else begin
        tick_count_reg <= tick_count_reg + 32'h00000001;
        tick_reg <= 1'b0;
    end
end

// demand moves one speed step every period ticks
always @(posedge clock or posedge rst) begin
    if (rst) begin
        time_count_reg <= 16'h0000;
        velocity_demand <= `RST_VEL_VALUE; // R11
    end else if ((power_state != ST_OP_ENABLED) && (power_state != ST_FAST_HALT)) begin
        time_count_reg <= 16'h0000;
        velocity_demand <= 16'h0000;
    end else if (tick_reg) begin
        if ((time_count_reg + 16'h0001) >= period) begin // R18
            time_count_reg <= 16'h0000;
            velocity_demand <= demand_next; // R18
        end else begin
            time_count_reg <= time_count_reg + 16'h0001;
        end
    end
end

// ----------------------------------------
// status word
// ----------------------------------------
reg [15:0] status_next;

// assemble flags from state and inputs
always @* begin
    status_next = 16'h0000;
    case (power_state)
        ST_NOT_READY: status_next[6:0] = 7'h00; // R8
        ST_INHIBITED: status_next[6:0] = 7'h60; // R8
        ST_READY: status_next[6:0] = 7'h21; // R8
        ST_SWITCHED_ON: status_next[6:0] = 7'h23; // R8
        ST_OP_ENABLED: status_next[6:0] = 7'h27; // R8
        ST_FAST_HALT: status_next[6:0] = 7'h07; // R9
        ST_FAULT_REACT: status_next[6:0] = 7'h2f; // R9
        ST_FAULT: status_next[6:0] = 7'h28; // R9
        default: status_next[6:0] = 7'h00;
    endcase
    if (power_state == ST_FAST_HALT) begin
        status_next[`BIT_FAST_HALT] = 1'b0; // R2
    end
    if (fault_active) begin
        status_next[`BIT_FAULT] = 1'b1; // R6
    end
    status_next[`BIT_VOLTAGE] = voltage_present_flag; // R6
    status_next[`BIT_WARNING] = warning_active; // R6
    status_next[`BIT_SYNC] = fieldbus_in_sync; // R3
    status_next[`BIT_REMOTE] = 1'b1; // R4
    status_next[`BIT_GOAL] = goal_reached_flag; // R6
    status_next[`BIT_LIMIT] = internal_limit_flag_reg; // R6
    status_next[`BIT_MODE_LO] = mode_specific_bits[0]; // R7
    status_next[`BIT_MODE_HI] = mode_specific_bits[1]; // R7
    status_next[`BIT_SPARE] = 1'b0;
    status_next[`BIT_LOOP] = (power_state == ST_OP_ENABLED) && feedback_loop_on; // R5
end

// status, limit flag, actual speed and rpm
always @(posedge clock or posedge rst) begin
    if (rst) begin
        status_word <= `RST_STATE_REPORT; // R20
        internal_limit_flag_reg <= 1'b0;
        velocity_actual_reg <= `RST_VEL_VALUE; // R11
        speed_rpm <= 32'h00000000;
    end else begin
        status_word <= status_next; // R1
        internal_limit_flag_reg <= clamp_hit; // R22
        velocity_actual_reg <= velocity_measured; // R11
        speed_rpm <= rpm_value; // R19
    end
end

// ----------------------------------------
// unit conversion
// ----------------------------------------
// demand times numerator over denominator, zero on bad divisor
always @* begin
    rpm_product = $signed({{48{velocity_demand[15]}}, velocity_demand}) *
        $signed({{32{speed_unit_numerator_reg[31]}}, speed_unit_numerator_reg});
    rpm_quotient = 64'h0000000000000000;
    if (speed_unit_denominator_reg != 32'h00000000) begin
        rpm_quotient = $signed(rpm_product) /
            $signed({{32{speed_unit_denominator_reg[31]}}, speed_unit_denominator_reg}); // R19
    end
    rpm_value = rpm_quotient[31:0];
end

// ----------------------------------------
// object access port
// ----------------------------------------
reg [31:0] read_value;
reg known;
reg writable;

// decode index and subindex
always @* begin
    read_value = 32'h00000000;
    known = 1'b1;
    writable = 1'b0;
    case (od_index)
        `IDX_STATE_REPORT: read_value = {16'h0000, status_word}; // R20
        `IDX_VEL_TARGET: begin
            read_value = {16'h0000, velocity_target_reg}; // R10
            writable = 1'b1;
        end
        `IDX_VEL_DEMAND: read_value = {16'h0000, velocity_demand}; // R11
        `IDX_VEL_ACTUAL: read_value = {16'h0000, velocity_actual_reg}; // R11
        `IDX_VEL_LIMITS: read_value = velocity_lower_limit_reg;
        `IDX_ACCEL_RAMP: read_value = accel_speed_step_reg;
        `IDX_DECEL_RAMP: read_value = decel_speed_step_reg;
        `IDX_FAST_STOP_RAMP: read_value = fast_stop_speed_step_reg;
        `IDX_UNIT_FACTOR: read_value = speed_unit_numerator_reg;
        default: known = 1'b0;
    endcase
    if (od_index > `IDX_VEL_ACTUAL && known) begin
        writable = 1'b1;
        if (od_sub == `SUB_VALUE) begin
            read_value = `SUB_COUNT_PAIR;
            writable = 1'b0;
        end else if (od_sub == `SUB_SECOND) begin
            case (od_index)
                `IDX_VEL_LIMITS: read_value = velocity_upper_limit_reg;
                `IDX_ACCEL_RAMP: read_value = {16'h0000, accel_time_step_reg};
                `IDX_DECEL_RAMP: read_value = {16'h0000, decel_time_step_reg};
                `IDX_FAST_STOP_RAMP: read_value = {16'h0000, fast_stop_time_step_reg};
                default: read_value = speed_unit_denominator_reg;
            endcase
        end else if (od_sub != `SUB_FIRST) begin
            known = 1'b0;
        end
    end else if (od_sub != `SUB_VALUE) begin
        known = 1'b0;
    end
end

// answer one cycle after a request
always @(posedge clock or posedge rst) begin
    if (rst) begin
        od_ack <= 1'b0;
        od_err <= 1'b0;
        od_rdata <= 32'h00000000;
    end else begin
        od_ack <= od_req;
        od_err <= od_req && (!known || (od_write && !writable));
        if (od_req && !od_write && known) begin
            od_rdata <= read_value;
        end
    end
end

// writable objects
always @(posedge clock or posedge rst) begin
    if (rst) begin
        velocity_target_reg <= `RST_VEL_TARGET; // R10
        velocity_lower_limit_reg <= `RST_LOWER_LIMIT; // R14
        velocity_upper_limit_reg <= `RST_UPPER_LIMIT; // R14
        accel_speed_step_reg <= `RST_RAMP_SPEED; // R15
        accel_time_step_reg <= `RST_RAMP_TIME; // R15
        decel_speed_step_reg <= `RST_RAMP_SPEED; // R16
        decel_time_step_reg <= `RST_RAMP_TIME; // R16
        fast_stop_speed_step_reg <= `RST_FAST_SPEED; // R17
        fast_stop_time_step_reg <= `RST_RAMP_TIME; // R17
        speed_unit_numerator_reg <= `RST_UNIT_FACTOR; // R19
        speed_unit_denominator_reg <= `RST_UNIT_FACTOR; // R19
    end else if (od_req && od_write && known && writable) begin
        case ({od_index, od_sub[1]})
            {`IDX_VEL_TARGET, 1'b0}: velocity_target_reg <= od_wdata[15:0]; // R10
            {`IDX_VEL_LIMITS, 1'b0}: velocity_lower_limit_reg <= od_wdata;
            {`IDX_VEL_LIMITS, 1'b1}: velocity_upper_limit_reg <= od_wdata;
            {`IDX_ACCEL_RAMP, 1'b0}: accel_speed_step_reg <= od_wdata;
            {`IDX_ACCEL_RAMP, 1'b1}: accel_time_step_reg <= od_wdata[15:0];
            {`IDX_DECEL_RAMP, 1'b0}: decel_speed_step_reg <= od_wdata;
            {`IDX_DECEL_RAMP, 1'b1}: decel_time_step_reg <= od_wdata[15:0];
            {`IDX_FAST_STOP_RAMP, 1'b0}: fast_stop_speed_step_reg <= od_wdata;
            {`IDX_FAST_STOP_RAMP, 1'b1}: fast_stop_time_step_reg <= od_wdata[15:0];
            {`IDX_UNIT_FACTOR, 1'b0}: speed_unit_numerator_reg <= od_wdata;
            {`IDX_UNIT_FACTOR, 1'b1}: speed_unit_denominator_reg <= od_wdata;
            default: velocity_target_reg <= velocity_target_reg;
        endcase
    end
end

endmodule // drive_status_velocity_mode
`default_nettype wire

// file: drive_status_velocity_mode_tb.sv
// bench for the status word and velocity setpoint block
// assumes design, checker and master model compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, want) begin tests_run++; if ((got) !== (want)) begin error_cnt++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, want); end end
module drive_status_velocity_mode_tb;
    localparam int TICK = 4;
    // inhibited bit and low nibble per power state; bit 5 comes from RUN_BIT
    localparam logic [4:0] CODE [0:7] = '{5'h00, 5'h10, 5'h01, 5'h03, 5'h07, 5'h07, 5'h0f, 5'h08};
    localparam logic [7:0] RUN_BIT = 8'hde;
    typedef struct packed {
        logic wr;
        logic [15:0] idx;
        logic [7:0] sub;
        logic [15:0] want;
        logic err;
    } row_t;
    // ----------------------------------------
    // object table: request beside answer
    // ----------------------------------------
    row_t rows [0:17] = '{
        '{1'b0, 16'h6042, 8'h00, 16'h00c8, 1'b0},
        '{1'b0, 16'h6043, 8'h00, 16'h0000, 1'b0},
        '{1'b1, 16'h6043, 8'h00, 16'h0000, 1'b1},
        '{1'b0, 16'h6044, 8'h00, 16'h1234, 1'b0},
        '{1'b1, 16'h6041, 8'h00, 16'h0000, 1'b1},
        '{1'b0, 16'h6046, 8'h01, 16'h0000, 1'b0},
        '{1'b0, 16'h6046, 8'h02, 16'h7530, 1'b0},
        '{1'b1, 16'h6046, 8'h00, 16'h0000, 1'b1},
        '{1'b0, 16'h6046, 8'h00, 16'h0002, 1'b0},
        '{1'b0, 16'h6048, 8'h01, 16'h01f4, 1'b0},
        '{1'b0, 16'h6048, 8'h02, 16'h0001, 1'b0},
        '{1'b0, 16'h6049, 8'h01, 16'h01f4, 1'b0},
        '{1'b0, 16'h6049, 8'h02, 16'h0001, 1'b0},
        '{1'b0, 16'h604a, 8'h01, 16'h1388, 1'b0},
        '{1'b0, 16'h604a, 8'h02, 16'h0001, 1'b0},
        '{1'b0, 16'h604c, 8'h01, 16'h0001, 1'b0},
        '{1'b0, 16'h604c, 8'h02, 16'h0001, 1'b0},
        '{1'b0, 16'h6045, 8'h00, 16'h0000, 1'b1}};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [2:0] ps = 3'h0;
    logic [5:0] fl = 6'h00; // loop, goal, sync, warning, fault, voltage
    logic [1:0] md = 2'h0;
    logic [31:0] rd;
    logic [1:0] resp;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    wire logic od_req, od_write, od_ack, od_err;
    wire logic [7:0] od_sub;
    wire logic [15:0] od_index, status_word, velocity_demand;
    wire logic [31:0] od_wdata, od_rdata, speed_rpm;

    drive_status_velocity_mode #(.RAMP_TICK_CYCLES(TICK)) drive_status_velocity_mode_inst (
        .clock(clock), .rst(rst), .power_state(ps), .voltage_present_flag(fl[0]), .fault_active(fl[1]),
        .warning_active(fl[2]), .fieldbus_in_sync(fl[3]), .goal_reached_flag(fl[4]), .feedback_loop_on(fl[5]),
        .mode_specific_bits(md), .velocity_measured(16'h1234), .od_req(od_req), .od_write(od_write),
        .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
        .od_err(od_err), .status_word(status_word), .velocity_demand(velocity_demand), .speed_rpm(speed_rpm));
    fieldbus_master_model fieldbus_master_model_inst (.clock(clock), .od_req(od_req), .od_write(od_write),
        .od_index(od_index), .od_sub(od_sub), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
        .od_err(od_err));

    // expected status word from state, flags, mode and limit
    function automatic logic [15:0] exp_status(input logic [2:0] s, input logic lim);
        exp_status = {fl[5] && s == 3'h4, 1'b0, md, lim, fl[4], 1'b1, fl[3], fl[2], CODE[s][4], RUN_BIT[s],
            fl[0], CODE[s][3] | fl[1], CODE[s][2:0]};
    endfunction
    // object write that must be accepted
    task automatic put(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
        fieldbus_master_model_inst.access(1'b1, idx, sub, d, rd, resp);
        `CHECK(resp, 2'h2)
    endtask
    // lets the ramp run for n ticks, then checks the demand
    task automatic settle(input int n, input logic [15:0] want);
        repeat (n * TICK + 3) @(negedge clock);
        `CHECK(velocity_demand, want)
    endtask
    // verdict and end of run
    task automatic report_and_stop;
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always #5 clock = ~clock;
    // cuts a hung run short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    // main sequence
    initial begin
        repeat (11) @(negedge clock);
        `CHECK({status_word, velocity_demand, od_ack}, 33'h0)
        @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < 18; i++) begin
            fieldbus_master_model_inst.access(rows[i].wr, rows[i].idx, rows[i].sub, 32'h00005a5a, rd, resp);
            `CHECK(resp, {1'b1, rows[i].err})
            if (!rows[i].err) `CHECK(rd, {16'h0000, rows[i].want})
        end
        for (int s = 0; s < 16; s++) begin
            ps = s[2:0];
            fl = {s[3], s[0], s[1], s[3] ^ s[0], s[2], s[3] ^ s[1]};
            md = s[1:0] ^ {2{s[3]}};
            repeat (2) @(negedge clock);
            `CHECK(status_word, exp_status(ps, 1'b0))
        end
        fl = 6'h00;
        put(16'h6046, 8'h02, 32'h00000064);
        put(16'h6046, 8'h01, 32'h00000032);
        put(16'h604c, 8'h01, 32'h0000003c);
        ps = 3'h4;
        settle(3, 16'h0064);
        `CHECK({status_word[11], speed_rpm}, {1'b1, 32'h00001770})
        put(16'h6042, 8'h00, 32'h00000014);
        settle(3, 16'h0032);
        `CHECK(status_word[11], 1'b1)
        put(16'h6042, 8'h00, 32'h00000046);
        settle(1, 16'h0046);
        `CHECK(status_word[11], 1'b0)
        put(16'h6042, 8'h00, 32'h0000ff38);
        settle(4, 16'hff9c);
        put(16'h6049, 8'h01, 32'h00000001);
        ps = 3'h5;
        settle(2, 16'h0000);
        put(16'h6048, 8'h01, 32'h00000008);
        put(16'h6048, 8'h02, 32'h00000002);
        ps = 3'h4;
        repeat (4 * TICK + 3) @(negedge clock);
        `CHECK(velocity_demand inside {16'hfff0, 16'hffe8}, 1'b1)
        rst = 1'b1;
        @(negedge clock);
        `CHECK({status_word, velocity_demand}, 32'h0)
        rst = 1'b0;
        fieldbus_master_model_inst.access(1'b0, 16'h6042, 8'h00, 32'h00000000, rd, resp);
        `CHECK({resp, rd}, {2'h2, 32'h000000c8})
        report_and_stop;
    end
endmodule // drive_status_velocity_mode_tb
`default_nettype wire

// file: fieldbus_master_model.sv
// fieldbus master model issuing object reads and writes
// assumes the block answers one cycle after a request pulse
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
    input wire logic clock,
    output logic od_req,
    output logic od_write,
    output logic [15:0] od_index,
    output logic [7:0] od_sub,
    output logic [31:0] od_wdata,
    input wire logic [31:0] od_rdata,
    input wire logic od_ack,
    input wire logic od_err
);
    // idle bus from time zero
    initial begin
        od_req = 1'b0;
        od_write = 1'b0;
        od_index = 16'h0000;
        od_sub = 8'h00;
        od_wdata = 32'h00000000;
    end
    // one request pulse, answer taken a cycle later
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, output logic [31:0] rd, output logic [1:0] resp);
        @(negedge clock);
        od_req = 1'b1;
        od_write = wr;
        od_index = idx;
        od_sub = sub;
        od_wdata = wd;
        @(negedge clock);
        // answer stands for one cycle only, so take it before releasing
        rd = od_rdata;
        resp = {od_ack, od_err};
        // released lines no longer show the request
        od_req = 1'b0;
        od_write = ~wr;
        od_index = ~idx;
        od_sub = ~sub;
        od_wdata = ~wd;
    endtask
endmodule // fieldbus_master_model
`default_nettype wire
